// file: rtl/flash_guard.sv
// Flash fault flag, emulation overlay decode and their Avalon-MM register slave
`timescale 1ns/1ns
`default_nettype none
`include "flash_guard_map.svh"

// Operation
// - Illegal flash event sets fault flag, protects
// - Flag resets 0; pin reset, standby clear
// - Flash read during program sets flag
// - Exception before program/erase sets flag
// - Sleep during program/erase sets flag
// - Watchdog reset leaves fault flag alone
// - Status low bits read one, ignore writes
// - Overlay off unless enable; rom window select
// - RAM source window from select, enables
// - Upper select bits set force lowest zero
// - Emulation fields writable only modes 2,4,7
// - Emulation enable blocks program and erase
// - Other modes: enable, rom select read zero; source select kept, locked
module flash_guard
    import flash_guard_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [2:0] mode_pins,
    input wire logic hw_standby_pin,
    input wire logic wdt_reset,
    input wire logic flash_busy,
    input wire logic pe_armed,
    input wire logic cpu_read,
    input wire logic [15:0] cpu_addr,
    input wire logic exc_start,
    input wire exception_kind_e exc_kind,
    input wire logic sleep_exec,
    output logic flash_fault_flag,
    output logic pe_blocked,
    output logic overlay_hit,
    output logic [15:0] ram_addr,
    output logic irq
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] mode_meta_reg;
    logic [2:0] mode_reg;
    logic standby_meta_reg;
    logic standby_reg;

    // Mode and standby pins come from outside the clock domain
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_meta_reg <= 3'h0;
            mode_reg <= 3'h0;
            standby_meta_reg <= 1'b0;
            standby_reg <= 1'b0;
        end else begin
            mode_meta_reg <= mode_pins;
            mode_reg <= mode_meta_reg;
            standby_meta_reg <= hw_standby_pin;
            standby_reg <= standby_meta_reg;
        end
    end

    // Decoding shared by lock logic and assertions
    function automatic logic mode_allows(input op_mode_t m);
        mode_allows = (m == 3'h2) || (m == 3'h4) || (m == 3'h7);
    endfunction

    logic emu_mode;
    assign emu_mode = mode_allows(mode_reg);

    // ****************************************
    // Bus access decode
    // ****************************************
    logic wr_fire;
    logic rd_fire;
    logic lane0;
    logic [7:0] wbyte;
    assign wr_fire = write && !waitrequest;
    assign rd_fire = read && !waitrequest;
    assign lane0 = byteenable[0];
    assign wbyte = writedata[7:0];

    // ****************************************
    // Control registers
    // ****************************************
    logic ovl_en_reg;
    logic [2:0] src_sel_reg;
    logic ram_en1_reg;
    logic ram_en2_reg;
    logic [2:0] rom_sel_reg;
    logic [2:0] src_sel_next;

    always_comb begin
        src_sel_next = wbyte[`FG_BIT_SRC_HI:`FG_BIT_SRC_LO];
        if (src_sel_next[2] && src_sel_next[1]) begin
            src_sel_next[0] = 1'b0;
        end
    end

    // Standby and watchdog reset both reinitialise the emulation setup
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ovl_en_reg <= 1'b0;
            src_sel_reg <= `FG_RST_FIELD;
            rom_sel_reg <= `FG_RST_FIELD;
            ram_en1_reg <= 1'b0;
            ram_en2_reg <= 1'b0;
        end else if (standby_reg || wdt_reset) begin
            ovl_en_reg <= 1'b0;
            src_sel_reg <= `FG_RST_FIELD;
            rom_sel_reg <= `FG_RST_FIELD;
            ram_en1_reg <= 1'b0;
            ram_en2_reg <= 1'b0;
        end else if (!emu_mode) begin
            ovl_en_reg <= 1'b0;
            rom_sel_reg <= `FG_RST_FIELD;
            if (wr_fire && lane0 && address == `FG_OFS_MEM_CONTROL) begin
                ram_en1_reg <= wbyte[`FG_BIT_RAM_EN1];
                ram_en2_reg <= wbyte[`FG_BIT_RAM_EN2];
            end
        end else if (wr_fire && lane0) begin
            if (address == `FG_OFS_EMU_CONTROL) begin
                ovl_en_reg <= wbyte[`FG_BIT_OVL_EN];
                src_sel_reg <= src_sel_next;
            end
            if (address == `FG_OFS_MEM_CONTROL) begin
                ram_en1_reg <= wbyte[`FG_BIT_RAM_EN1];
                ram_en2_reg <= wbyte[`FG_BIT_RAM_EN2];
                rom_sel_reg <= wbyte[`FG_BIT_ROM_HI:`FG_BIT_ROM_LO];
            end
        end
    end

    // ****************************************
    // Overlay decode
    // ****************************************
    logic ovl_on;
    logic [15:0] flash_base;
    logic [15:0] ram_base;
    logic in_window;
    assign ovl_on = ovl_en_reg && ram_en1_reg && ram_en2_reg;
    assign flash_base = `FG_FLASH_WIN_BASE + {4'h0, rom_sel_reg, 9'h000};
    assign ram_base = `FG_RAM_WIN_BASE + {4'h0, src_sel_reg, 9'h000};
    assign in_window = ovl_on && (cpu_addr[15:`FG_WIN_SHIFT] == flash_base[15:`FG_WIN_SHIFT]);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            overlay_hit <= 1'b0;
            ram_addr <= 16'h0000;
        end else begin
            overlay_hit <= cpu_read && in_window;
            ram_addr <= {ram_base[15:`FG_WIN_SHIFT], cpu_addr[`FG_WIN_SHIFT-1:0]};
        end
    end

    // ****************************************
    // Fault detection
    // ****************************************
    logic illegal_read;
    logic illegal_exc;
    logic illegal_sleep;
    logic fault_event;
    assign illegal_read = cpu_read && flash_busy && !in_window;
    // Exceptions other than the exempt kinds
    assign illegal_exc = exc_start && (pe_armed || flash_busy) && !(exc_kind inside
        {EXC_RESET, EXC_TRACE, EXC_INVALID, EXC_TRAP, EXC_ZERO_DIV});
    assign illegal_sleep = sleep_exec && flash_busy;
    assign fault_event = illegal_read || illegal_exc || illegal_sleep;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flash_fault_flag <= 1'b0;
        end else if (standby_reg) begin
            flash_fault_flag <= 1'b0;
        end else if (fault_event) begin
            flash_fault_flag <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pe_blocked <= 1'b0;
        end else begin
            pe_blocked <= ovl_en_reg || flash_fault_flag;
        end
    end

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    logic irq_stat_reg;
    logic irq_mask_reg;
    logic fault_prev_reg;

    // Rising edge of the fault flag is the event; set wins over read clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fault_prev_reg <= 1'b0;
            irq_stat_reg <= 1'b0;
        end else begin
            fault_prev_reg <= flash_fault_flag;
            if (flash_fault_flag && !fault_prev_reg) begin
                irq_stat_reg <= 1'b1;
            end else if (rd_fire && address == `FG_OFS_IRQ_STATUS) begin
                irq_stat_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_mask_reg <= 1'b0;
        end else if (wr_fire && lane0 && address == `FG_OFS_IRQ_MASK) begin
            irq_mask_reg <= wbyte[`FG_IRQ_FAULT];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_stat_reg && irq_mask_reg;
        end
    end

    // ****************************************
    // Avalon-MM answer
    // ****************************************
    logic [7:0] rd_byte;

    // Low status bits read as ones
    always_comb begin
        case (address)
            `FG_OFS_ERROR_STATUS: rd_byte = {flash_fault_flag, `FG_STATUS_LOW_ONES};
            `FG_OFS_EMU_CONTROL: rd_byte = {ovl_en_reg, 3'h0, src_sel_reg, 1'b0};
            `FG_OFS_MEM_CONTROL: rd_byte = {ram_en1_reg, 1'b0, ram_en2_reg, 2'h0, rom_sel_reg};
            `FG_OFS_IRQ_STATUS: rd_byte = {7'h00, irq_stat_reg};
            `FG_OFS_IRQ_MASK: rd_byte = {7'h00, irq_mask_reg};
            default: rd_byte = `FG_RST_BYTE;
        endcase
    end

    // One wait state: answer is captured while waitrequest falls
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
            if (read && waitrequest) begin
                readdata <= {24'h000000, rd_byte};
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence busy_read_s;
        cpu_read && flash_busy && !in_window && !standby_reg;
    endsequence

    sequence emu_write_s;
        wr_fire && lane0 && address == `FG_OFS_EMU_CONTROL && emu_mode
            && !standby_reg && !wdt_reset;
    endsequence

    fault_set_read_a: assert property (@(posedge clock) disable iff (rst)
        busy_read_s |=> flash_fault_flag)
        else $error("busy flash read did not set fault");

    fault_sticky_a: assert property (@(posedge clock) disable iff (rst)
        flash_fault_flag && !standby_reg |=> flash_fault_flag)
        else $error("fault flag dropped without standby");

    wdt_keeps_a: assert property (@(posedge clock) disable iff (rst)
        flash_fault_flag && wdt_reset && !standby_reg |=> flash_fault_flag)
        else $error("watchdog reset cleared fault");

    sleep_sets_a: assert property (@(posedge clock) disable iff (rst)
        sleep_exec && flash_busy |=> flash_fault_flag || $past(standby_reg))
        else $error("sleep during activity missed");

    status_ones_a: assert property (@(posedge clock) disable iff (rst)
        read && waitrequest && address == `FG_OFS_ERROR_STATUS
            |=> readdata[6:0] == 7'h7f)
        else $error("status low bits not ones");

    src_forbid_a: assert property (@(posedge clock) disable iff (rst)
        src_sel_reg != `FG_SRC_FORBIDDEN)
        else $error("forbidden source code in effect");

    lock_zero_a: assert property (@(posedge clock) disable iff (rst)
        !emu_mode |=> !ovl_en_reg && rom_sel_reg == 3'h0)
        else $error("emulation fields not locked");

    emu_write_a: assert property (@(posedge clock) disable iff (rst)
        emu_write_s |=> ovl_en_reg == $past(wbyte[7]))
        else $error("emulation write not taken");

    block_pe_a: assert property (@(posedge clock) disable iff (rst)
        ovl_en_reg |=> pe_blocked)
        else $error("emulation did not block program");

    redirect_a: assert property (@(posedge clock) disable iff (rst)
        cpu_read && in_window |=> overlay_hit
            && ram_addr[8:0] == $past(cpu_addr[8:0]))
        else $error("overlay read not redirected");

    overlay_off_a: assert property (@(posedge clock) disable iff (rst)
        !(ovl_en_reg && ram_en1_reg && ram_en2_reg) |=> !overlay_hit)
        else $error("overlay active while disabled");

    bus_answer_a: assert property (@(posedge clock) disable iff (rst)
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer timing wrong");

endmodule // flash_guard

`default_nettype wire

// file: rtl/flash_guard_map.svh
// Register offsets, field positions, reset values and window bases of the flash guard
`ifndef FLASH_GUARD_MAP_SVH
`define FLASH_GUARD_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define FG_OFS_ERROR_STATUS 5'h00
`define FG_OFS_EMU_CONTROL 5'h04
`define FG_OFS_MEM_CONTROL 5'h08
`define FG_OFS_IRQ_STATUS 5'h0c
`define FG_OFS_IRQ_MASK 5'h10

// ****************************************
// Field positions
// ****************************************
`define FG_BIT_FAULT 7
`define FG_STATUS_LOW_ONES 7'h7f
`define FG_BIT_OVL_EN 7
`define FG_BIT_SRC_HI 3
`define FG_BIT_SRC_LO 1
`define FG_BIT_RAM_EN1 7
`define FG_BIT_RAM_EN2 5
`define FG_BIT_ROM_HI 2
`define FG_BIT_ROM_LO 0
`define FG_IRQ_FAULT 0

// ****************************************
// Reset values
// ****************************************
`define FG_RST_BYTE 8'h00
`define FG_RST_FIELD 3'h0

// ****************************************
// Overlay windows (512-byte blocks)
// ****************************************
`define FG_FLASH_WIN_BASE 16'h3000
`define FG_RAM_WIN_BASE 16'hf000
`define FG_WIN_SHIFT 9
`define FG_SRC_FORBIDDEN 3'h7

`endif

// file: rtl/flash_guard_pkg.sv
// Types shared by the flash guard block
package flash_guard_pkg;

    // Kind of hardware exception sequence that the CPU reports
    typedef enum logic [2:0] {
        EXC_RESET,
        EXC_TRACE,
        EXC_INVALID,
        EXC_TRAP,
        EXC_ZERO_DIV,
        EXC_OTHER
    } exception_kind_e;

    // Operating modes as coded on the mode pins
    typedef logic [2:0] op_mode_t;

endpackage

// file: verif/cpu_core_model.sv
// Behavioural CPU core driving read, exception and sleep strobes
`timescale 1ns/1ns
`default_nettype none
module cpu_core_model
    import flash_guard_pkg::*;
(
    input wire logic clock,
    output logic cpu_read,
    output logic [15:0] cpu_addr,
    output logic exc_start,
    output var exception_kind_e exc_kind,
    output logic sleep_exec
);
    // Strobes idle low from time zero
    initial begin
        cpu_read = 1'b0;
        cpu_addr = 16'h0000;
        exc_start = 1'b0;
        exc_kind = EXC_OTHER;
        sleep_exec = 1'b0;
    end
    // One-cycle read; the address then flips so no stale value can hit
    task automatic fetch(input logic [15:0] a);
        @(posedge clock);
        cpu_read <= 1'b1;
        cpu_addr <= a;
        @(posedge clock);
        cpu_read <= 1'b0;
        cpu_addr <= ~a;
    endtask
    // Exception sequence start pulse
    task automatic raise(input exception_kind_e k);
        @(posedge clock);
        exc_start <= 1'b1;
        exc_kind <= k;
        @(posedge clock);
        exc_start <= 1'b0;
    endtask
    // Sleep instruction pulse
    task automatic sleep_now();
        @(posedge clock);
        sleep_exec <= 1'b1;
        @(posedge clock);
        sleep_exec <= 1'b0;
    endtask
endmodule // cpu_core_model
`default_nettype wire

// file: verif/flash_guard_test.sv
// Register, overlay and fault scenarios for the flash guard
`timescale 1ns/1ns
`default_nettype none
`include "flash_guard_map.svh"
`define CHECK_EQ(what, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
        end \
    end
module flash_guard_test
    import flash_guard_pkg::*;
;
    localparam logic [4:0] ST = `FG_OFS_ERROR_STATUS, EMU = `FG_OFS_EMU_CONTROL;
    localparam logic [4:0] MEM = `FG_OFS_MEM_CONTROL, IST = `FG_OFS_IRQ_STATUS;
    localparam logic [4:0] MSK = `FG_OFS_IRQ_MASK;
    logic clock, rst, read, write, waitrequest, hw_standby_pin, wdt_reset, flash_busy;
    logic pe_armed, cpu_read, exc_start, sleep_exec, flash_fault_flag, pe_blocked;
    logic overlay_hit, irq;
    logic [4:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata;
    logic [2:0] mode_pins, rom, src, es;
    logic [15:0] cpu_addr, ram_addr, off;
    logic [7:0] q;
    exception_kind_e exc_kind;
    logic [2:0] modes [3] = '{3'h2, 3'h4, 3'h7};
    int errors, n_checks, cycles;

    // ****************************************
    // Design and CPU partner
    // ****************************************
    flash_guard dut (.clock(clock), .rst(rst), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .mode_pins(mode_pins),
        .hw_standby_pin(hw_standby_pin), .wdt_reset(wdt_reset), .flash_busy(flash_busy),
        .pe_armed(pe_armed), .cpu_read(cpu_read), .cpu_addr(cpu_addr),
        .exc_start(exc_start), .exc_kind(exc_kind), .sleep_exec(sleep_exec),
        .flash_fault_flag(flash_fault_flag), .pe_blocked(pe_blocked),
        .overlay_hit(overlay_hit), .ram_addr(ram_addr), .irq(irq));
    cpu_core_model cpu (.clock(clock), .cpu_read(cpu_read), .cpu_addr(cpu_addr),
        .exc_start(exc_start), .exc_kind(exc_kind), .sleep_exec(sleep_exec));

    // Free-running 20 MHz clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Hang guard, well above the several hundred cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Avalon access held until waitrequest is seen low at an edge
    task automatic bus(input logic wr_en, input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        read <= ~wr_en;
        write <= wr_en;
        address <= a;
        writedata <= {24'h000000, d};
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string what);
        bus(1'b0, a, 8'h00);
        `CHECK_EQ(what, exp, q)
    endtask
    // Standby held past the two-flop synchroniser
    task automatic standby();
        @(posedge clock);
        hw_standby_pin <= 1'b1;
        repeat (4) @(posedge clock);
        hw_standby_pin <= 1'b0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        rst = 1'b1; address = 5'h00; read = 1'b0; write = 1'b0; byteenable = 4'hf;
        writedata = 32'h0; mode_pins = 3'h0; hw_standby_pin = 1'b0; wdt_reset = 1'b0;
        flash_busy = 1'b0; pe_armed = 1'b0; errors = 0; n_checks = 0; cycles = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        rd(ST, 8'h7f, "status reset");
        wr(ST, 8'hff);
        rd(ST, 8'h7f, "status write");
        // Mode 0: emulation fields locked, RAM enables still writable
        wr(EMU, 8'h8e);
        wr(MEM, 8'ha7);
        rd(EMU, 8'h00, "emu locked");
        rd(MEM, 8'ha0, "rom locked");
        foreach (modes[m]) begin
            @(posedge clock);
            mode_pins <= modes[m];
            repeat (3) @(posedge clock);
            for (int i = 0; i < 8; i++) begin
                rom = 3'(i);
                src = 3'(7 - i);
                es = (src == 3'h7) ? 3'h6 : src;
                off = 16'(i * 37 + 5);
                wr(EMU, {1'b1, 3'h0, src, 1'b0});
                wr(MEM, {5'b10100, rom});
                rd(EMU, {1'b1, 3'h0, es, 1'b0}, "emu field");
                rd(MEM, {5'b10100, rom}, "rom field");
                cpu.fetch(16'h3000 + 16'(rom) * 16'h0200 + off);
                @(negedge clock);
                `CHECK_EQ("overlay hit", 1'b1, overlay_hit)
                `CHECK_EQ("ram addr", 16'hf000 + 16'(es) * 16'h0200 + off, ram_addr)
                `CHECK_EQ("pe blocked", 1'b1, pe_blocked)
                cpu.fetch(16'h3000 + 16'(rom + 3'h1) * 16'h0200 + off);
                @(negedge clock);
                `CHECK_EQ("other window", 1'b0, overlay_hit)
            end
        end
        wr(EMU, 8'h00);
        cpu.fetch(16'h3e00);
        @(negedge clock);
        `CHECK_EQ("enable off", 1'b0, overlay_hit)
        `CHECK_EQ("pe free", 1'b0, pe_blocked)
        wr(EMU, 8'h80);
        wr(MEM, 8'h87);
        cpu.fetch(16'h3e10);
        @(negedge clock);
        `CHECK_EQ("ram off", 1'b0, overlay_hit)
        wr(MEM, 8'ha7);
        wr(MSK, 8'h01);
        // Lane 0 off: the mask write must be dropped
        byteenable <= 4'he;
        wr(MSK, 8'h00);
        byteenable <= 4'hf;
        rd(MSK, 8'h01, "lane refused");
        rd(5'h14, 8'h00, "unmapped");
        @(posedge clock);
        flash_busy <= 1'b1;
        cpu.fetch(16'h3e20);
        @(negedge clock);
        `CHECK_EQ("overlaid read", 1'b0, flash_fault_flag)
        cpu.fetch(16'h1000);
        @(negedge clock);
        `CHECK_EQ("busy read", 1'b1, flash_fault_flag)
        repeat (3) @(posedge clock);
        flash_busy <= 1'b0;
        @(negedge clock);
        `CHECK_EQ("irq raised", 1'b1, irq)
        rd(ST, 8'hff, "status fault");
        rd(IST, 8'h01, "irq status");
        rd(IST, 8'h00, "irq cleared");
        @(negedge clock);
        `CHECK_EQ("irq low", 1'b0, irq)
        wr(ST, 8'h00);
        rd(ST, 8'hff, "fault sticky");
        @(posedge clock);
        wdt_reset <= 1'b1;
        @(posedge clock);
        wdt_reset <= 1'b0;
        rd(ST, 8'hff, "wdt keeps");
        rd(EMU, 8'h00, "wdt clears");
        @(negedge clock);
        `CHECK_EQ("fault blocks", 1'b1, pe_blocked)
        standby();
        rd(ST, 8'h7f, "standby clear");
        for (int k = 0; k < 6; k++) begin
            @(posedge clock);
            pe_armed <= 1'b1;
            cpu.raise(exception_kind_e'(k));
            @(negedge clock);
            `CHECK_EQ("exception", exception_kind_e'(k) == EXC_OTHER, flash_fault_flag)
            @(posedge clock);
            pe_armed <= 1'b0;
            standby();
        end
        cpu.sleep_now();
        @(negedge clock);
        `CHECK_EQ("idle sleep", 1'b0, flash_fault_flag)
        @(posedge clock);
        flash_busy <= 1'b1;
        cpu.sleep_now();
        @(negedge clock);
        `CHECK_EQ("busy sleep", 1'b1, flash_fault_flag)
        @(posedge clock);
        flash_busy <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        `CHECK_EQ("pin reset", 1'b0, flash_fault_flag)
        print_verdict();
    end
endmodule // flash_guard_test
`default_nettype wire
